// [hw/dma_handshake_pkg.sv]
// Constants and types shared by the DMA request/grant handshake engine.
// Assumes a single 20 MHz clock that also paces the external bus.
package dma_handshake_pkg;

    localparam int unsigned DATA_WIDTH     = 32;
    localparam int unsigned ADDR_WIDTH     = 24;
    localparam int unsigned SELECT_WIDTH   = 4;
    localparam int unsigned WAIT_WIDTH     = 4;
    localparam int unsigned FIFO_DEPTH     = 8;

    // Clock and one external clock period expressed in cycles
    localparam int unsigned CLOCK_HZ       = 20_000_000;
    localparam int unsigned CLOCK_PERIOD_NS = 1_000_000_000 / CLOCK_HZ;
    localparam int unsigned EXT_PERIOD_NS  = 50;
    localparam int unsigned EXT_PERIOD_CYCLES =
        (EXT_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // Mode encodings on mode_i
    localparam logic [1:0] MODE_HANDSHAKE     = 2'h0;
    localparam logic [1:0] MODE_EXT_HANDSHAKE = 2'h1;
    localparam logic [1:0] MODE_PACED_MASTER  = 2'h2;

    // Values after reset
    localparam logic [ADDR_WIDTH-1:0]   RESET_ADDRESS = 24'h000000;
    localparam logic [DATA_WIDTH-1:0]   RESET_DATA    = 32'h00000000;
    localparam logic [SELECT_WIDTH-1:0] SELECT_IDLE   = 4'hF;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_RECOVER,
        ST_GAP
    } dma_state_t;

endpackage : dma_handshake_pkg

// [hw/dma_request_grant_handshake.sv]
// DMA request/grant handshake engine with its data FIFO.
// Overview of operation
// - A transfer starts only after the peripheral drives dma_request_n low.
// - In handshake mode the grant strobe marks when data is latched or driven.
// - External handshake mode uses address, strobes, selects, ack and grant.
// - Paced master mode runs plain bus cycles and keeps the grant high.
// - Holding the request low stretches a write; its data is driven from the start.
// - Holding the request low stretches a read by one period per cycle.
// - Each configured wait state adds one period to the grant low time.
// - An enabled idle cycle adds one period of grant high before the next.
// - The request counts in a cycle only when sampled low at that edge.
// Assumes dma_request_n_i and ack_i are already synchronous to ref_clk_i,
// and that mode_i and dir_i only change while enable_i is low.
`timescale 1ns/1ns
`default_nettype none

module dma_fifo
#(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8
)
(
    input  wire logic             ref_clk_i,    // Clock
    input  wire logic             rst_n_i,      // Sync reset, active low
    input  wire logic             in_valid_i,   // Write side valid
    output logic                  in_ready_o,   // Write side ready
    input  wire logic [WIDTH-1:0] in_data_i,    // Write side data
    output logic                  out_valid_o,  // Read side valid
    input  wire logic             out_ready_i,  // Read side ready
    output logic      [WIDTH-1:0] out_data_o    // Read side data
);
    localparam int unsigned PW = $clog2(DEPTH);

    // Pointer wrap relies on a power of two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("dma_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_ptr;
    logic [PW:0]      rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready_o  = (wr_ptr - rd_ptr) != (PW+1)'(DEPTH);
    assign out_valid_o = wr_ptr != rd_ptr;
    assign out_data_o  = mem[rd_ptr[PW-1:0]];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge ref_clk_i)
    begin
        if (push)
            mem[wr_ptr[PW-1:0]] <= in_data_i;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end

endmodule : dma_fifo

module dma_request_grant_handshake
    import dma_handshake_pkg::*;
#(
    parameter int unsigned WAIT_W = WAIT_WIDTH,
    parameter int unsigned DEPTH  = FIFO_DEPTH
)
(
    input  wire logic                    ref_clk_i,          // 20 MHz clock
    input  wire logic                    rst_n_i,            // Sync reset
    input  wire logic                    enable_i,           // Channel on
    input  wire logic [1:0]              mode_i,             // Handshake mode
    input  wire logic                    dir_i,              // 1 = outbound
    input  wire logic [WAIT_W-1:0]       wait_states_i,      // Wait states
    input  wire logic                    idle_cycle_en_i,    // Bus idle cycle
    input  wire logic [ADDR_WIDTH-1:0]   base_address_i,     // Start address
    input  wire logic [SELECT_WIDTH-1:0] select_i,           // Bank to select
    input  wire logic                    dma_request_n_i,    // Request
    output logic                         dma_grant_n_o,      // Grant strobe
    output logic [ADDR_WIDTH-1:0]        external_address_bus_o, // Address
    output logic [SELECT_WIDTH-1:0]      memory_select_n_o,  // Selects
    output logic                         rd_n_o,             // Read strobe
    output logic                         wr_n_o,             // Write strobe
    input  wire logic                    ack_i,              // Bus acknowledge
    input  wire logic [DATA_WIDTH-1:0]   data_i,             // Bus data in
    output logic [DATA_WIDTH-1:0]        data_o,             // Bus data out
    output logic                         data_oe_o,          // Bus data drive
    input  wire logic                    s_valid_i,          // Outbound valid
    output logic                         s_ready_o,          // Outbound ready
    input  wire logic [DATA_WIDTH-1:0]   s_data_i,           // Outbound data
    output logic                         m_valid_o,          // Inbound valid
    input  wire logic                    m_ready_i,          // Inbound ready
    output logic [DATA_WIDTH-1:0]        m_data_o,           // Inbound data
    output logic                         busy_o,             // Transfer active
    output logic                         done_o              // Transfer ended
);
    if (WAIT_W < 1 || WAIT_W > 8)
    begin : g_bad_wait_w
        $error("dma_request_grant_handshake: WAIT_W out of range");
    end

    dma_state_t        state;
    logic [WAIT_W-1:0] wait_cnt;
    logic              req_armed;
    logic              start;
    logic              capture;
    logic              finish;
    logic              fifo_in_valid;
    logic              fifo_in_ready;
    logic [DATA_WIDTH-1:0] fifo_in_data;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [DATA_WIDTH-1:0] fifo_out_data;

    // A new transfer needs a fresh low request and room or data in the FIFO
    assign start = (state == ST_IDLE) & enable_i & ~dma_request_n_i
                 & req_armed & (mode_i != 2'h3)
                 & (dir_i ? fifo_out_valid : fifo_in_ready);

    // Wait states first, then a request still low keeps the access open
    assign finish = (state == ST_ACCESS) & (wait_cnt == '0)
                  & dma_request_n_i
                  & ((mode_i == MODE_HANDSHAKE) | ack_i);
    assign capture = finish & ~dir_i;

    // Request must go high again so one long low is not taken twice
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            req_armed <= 1'b0;
        else if (start)
            req_armed <= 1'b0;
        else if (dma_request_n_i)
            req_armed <= 1'b1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            state    <= ST_IDLE;
            wait_cnt <= '0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (start)
                    begin
                        state    <= ST_ACCESS;
                        wait_cnt <= wait_states_i;
                    end
                ST_ACCESS:
                    if (wait_cnt != '0)
                        wait_cnt <= wait_cnt - 1'b1;
                    else if (finish)
                        state <= ST_RECOVER;
                ST_RECOVER:
                    state <= idle_cycle_en_i ? ST_GAP : ST_IDLE;
                ST_GAP:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Strobes change at the same edge as the state so they come from flops
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            dma_grant_n_o     <= 1'b1;
            rd_n_o            <= 1'b1;
            wr_n_o            <= 1'b1;
            memory_select_n_o <= SELECT_IDLE;
        end
        else if (start)
        begin
            dma_grant_n_o     <= (mode_i == MODE_PACED_MASTER);
            rd_n_o            <= dir_i;
            wr_n_o            <= ~dir_i;
            memory_select_n_o <= (mode_i == MODE_HANDSHAKE)
                               ? SELECT_IDLE : ~select_i;
        end
        else if (finish)
        begin
            dma_grant_n_o     <= 1'b1;
            rd_n_o            <= 1'b1;
            wr_n_o            <= 1'b1;
            memory_select_n_o <= SELECT_IDLE;
        end
    end

    // Address steps per transfer in the modes that use the address bus
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            external_address_bus_o <= RESET_ADDRESS;
        else if (!enable_i)
            external_address_bus_o <= base_address_i;
        else if (finish && mode_i != MODE_HANDSHAKE)
            external_address_bus_o <= external_address_bus_o + 1'b1;
    end

    // Outbound word is held on the bus for the whole stretched access
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            data_o    <= RESET_DATA;
            data_oe_o <= 1'b0;
        end
        else if (start && dir_i)
        begin
            data_o    <= fifo_out_data;
            data_oe_o <= 1'b1;
        end
        else if (finish)
            data_oe_o <= 1'b0;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            done_o <= 1'b0;
        else
            done_o <= finish;
    end

    assign busy_o = (state != ST_IDLE);

    // Inbound data is taken only after the request is released
    assign fifo_in_valid  = dir_i ? s_valid_i : capture;
    assign fifo_in_data   = dir_i ? s_data_i : data_i;
    assign s_ready_o      = dir_i & fifo_in_ready;
    assign fifo_out_ready = dir_i ? start : m_ready_i;
    assign m_valid_o      = ~dir_i & fifo_out_valid;
    assign m_data_o       = fifo_out_data;

    dma_fifo #(
        .WIDTH (DATA_WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

endmodule : dma_request_grant_handshake

`default_nettype wire

// [sim/dma_handshake_props.sv]
// Concurrent checks on the DMA request/grant handshake engine ports.
// Bound onto the top module; single clock domain, sync reset.
`timescale 1ns/1ns
`default_nettype none
module dma_handshake_props
    import dma_handshake_pkg::*;
#(
    parameter int unsigned WAIT_W = 4
)
(
    input wire logic                    ref_clk_i,         // Clock
    input wire logic                    rst_n_i,           // Reset
    input wire logic [1:0]              mode_i,            // Mode
    input wire logic                    dir_i,             // Direction
    input wire logic [WAIT_W-1:0]       wait_states_i,     // Waits
    input wire logic                    idle_cycle_en_i,   // Idle cycle
    input wire logic [SELECT_WIDTH-1:0] select_i,          // Bank
    input wire logic                    dma_request_n_i,   // Request
    input wire logic                    dma_grant_n_o,     // Grant
    input wire logic [SELECT_WIDTH-1:0] memory_select_n_o, // Selects
    input wire logic                    rd_n_o,            // Read strobe
    input wire logic                    wr_n_o,            // Write strobe
    input wire logic                    data_oe_o,         // Data drive
    input wire logic                    done_o             // Done
);
    logic [7:0] low_len;

    // Length of the current grant low pulse
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i || dma_grant_n_o)
            low_len <= 8'h00;
        else
            low_len <= low_len + 8'h01;
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_req_starts: assert property (
        $fell(dma_grant_n_o) |-> !$past(dma_request_n_i))
        else $error("grant fell without a request");
    a_strobe_dir: assert property (
        !dma_grant_n_o |-> (wr_n_o == !dir_i && rd_n_o == dir_i))
        else $error("strobe does not overlap grant");
    a_out_drive: assert property (
        (!dma_grant_n_o && dir_i) |-> data_oe_o)
        else $error("outbound data not driven under grant");
    a_ext_selects: assert property (
        (mode_i == MODE_EXT_HANDSHAKE && !dma_grant_n_o)
        |-> memory_select_n_o == ~select_i)
        else $error("selects wrong in external handshake");
    a_paced_grant: assert property (
        (mode_i == MODE_PACED_MASTER && $past(mode_i) == MODE_PACED_MASTER)
        |-> dma_grant_n_o)
        else $error("grant driven in paced mode");
    a_req_holds: assert property (
        (!dma_grant_n_o && !dma_request_n_i) |=> !dma_grant_n_o)
        else $error("access ended while request low");
    a_wait_len: assert property (
        $rose(dma_grant_n_o) |-> low_len > 8'(wait_states_i))
        else $error("grant low shorter than wait states");
    // Without the idle cycle the grant may fall again at the third edge
    a_idle_gap: assert property (
        ($rose(dma_grant_n_o) && idle_cycle_en_i) |-> dma_grant_n_o [*3])
        else $error("idle cycle missing after grant");
    a_done_marks: assert property (
        $rose(dma_grant_n_o) |-> done_o)
        else $error("grant rose without done");
    a_done_pulse: assert property (
        done_o |=> !done_o)
        else $error("done longer than one cycle");

    c_idle: cover property ($rose(dma_grant_n_o) && idle_cycle_en_i);
    c_paced: cover property (!rd_n_o && mode_i == MODE_PACED_MASTER);
    c_hold: cover property (!dma_grant_n_o && !dma_request_n_i);
endmodule : dma_handshake_props

bind dma_request_grant_handshake dma_handshake_props #(.WAIT_W(WAIT_W))
    i_dma_handshake_props
(
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .mode_i(mode_i),
    .dir_i(dir_i), .wait_states_i(wait_states_i),
    .idle_cycle_en_i(idle_cycle_en_i), .select_i(select_i),
    .dma_request_n_i(dma_request_n_i), .dma_grant_n_o(dma_grant_n_o),
    .memory_select_n_o(memory_select_n_o), .rd_n_o(rd_n_o),
    .wr_n_o(wr_n_o), .data_oe_o(data_oe_o), .done_o(done_o)
);
`default_nettype wire

// [sim/dma_peripheral_model.sv]
// Behavioural peripheral that requests DMA transfers from the engine.
// Assumes strobes registered on ref_clk_i; tb calls transfer().
`timescale 1ns/1ns
`default_nettype none
module dma_peripheral_model
(
    input  wire logic   ref_clk_i,       // Clock
    input  wire logic   rd_n_i,          // Read strobe
    input  wire logic   wr_n_i,          // Write strobe
    output logic        dma_request_n_o, // Request
    output logic        ack_o,           // Acknowledge
    output logic [31:0] data_o           // Bus data
);
    initial
    begin
        dma_request_n_o = 1'b1;
        ack_o = 1'b0;
        data_o = 32'h5A5A5A5A;
    end

    // Gives up after a bounded wait so a refused request cannot hang
    task automatic transfer(input int hold, input logic [31:0] word);
        int k;
        @(posedge ref_clk_i);
        dma_request_n_o <= 1'b0;
        k = 0;
        do @(posedge ref_clk_i); while (rd_n_i && wr_n_i && ++k < 40);
        repeat (hold) @(posedge ref_clk_i);
        dma_request_n_o <= 1'b1;
        data_o <= word;
        ack_o <= 1'b1;
        do @(posedge ref_clk_i); while (!(rd_n_i && wr_n_i) && ++k < 80);
        ack_o <= 1'b0;
        data_o <= ~word;
    endtask : transfer
endmodule : dma_peripheral_model
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the DMA request/grant handshake engine.
// Peripheral model drives request, ack and inbound bus data.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dma_handshake_pkg::*;
    localparam logic [23:0] BASE = 24'h000100;
    logic clk, rst_n, en, dir, idle, s_valid, s_ready, m_valid, m_ready;
    logic req_n, ack, grant_n, rd_n, wr_n, oe, busy, done;
    logic [1:0]  mode;
    logic [3:0]  waits, msel;
    logic [23:0] addr;
    logic [31:0] din, dout, s_data, m_data, dcap;
    logic [7:0]  lowcnt, gcnt, dcnt;
    int          num_errors, total_checks;

    dma_request_grant_handshake i_dma_request_grant_handshake
    (
        .ref_clk_i(clk), .rst_n_i(rst_n), .enable_i(en), .mode_i(mode),
        .dir_i(dir), .wait_states_i(waits), .idle_cycle_en_i(idle),
        .base_address_i(BASE), .select_i(4'h2), .dma_request_n_i(req_n),
        .dma_grant_n_o(grant_n), .external_address_bus_o(addr),
        .memory_select_n_o(msel), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .ack_i(ack), .data_i(din), .data_o(dout), .data_oe_o(oe),
        .s_valid_i(s_valid), .s_ready_o(s_ready), .s_data_i(s_data),
        .m_valid_o(m_valid), .m_ready_i(m_ready), .m_data_o(m_data),
        .busy_o(busy), .done_o(done)
    );
    dma_peripheral_model i_dma_peripheral_model
    (
        .ref_clk_i(clk), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .dma_request_n_o(req_n), .ack_o(ack), .data_o(din)
    );

    always @(posedge clk)
    begin
        if (!(rd_n && wr_n))
            lowcnt <= lowcnt + 8'h01;
        if (!wr_n)
            dcap <= dout;
        if (!grant_n)
            gcnt <= gcnt + 8'h01;
        if (done)
            dcnt <= dcnt + 8'h01;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic cfg(input logic [1:0] m, input logic d,
                       input logic [3:0] w, input logic i);
        @(posedge clk);
        en <= 1'b0;
        mode <= m;
        dir <= d;
        waits <= w;
        idle <= i;
        @(posedge clk);
        en <= 1'b1;
    endtask : cfg

    // Strobe low length is max(waits + 1, hold + 2) with this model
    task automatic xfer(input int hold, input logic [31:0] w, input int len);
        logic [7:0] s;
        s = lowcnt;
        i_dma_peripheral_model.transfer(hold, w);
        check(32'(lowcnt - s), 32'(len));
    endtask : xfer

    task automatic drain(input int n, input logic [31:0] first);
        int k;
        m_ready <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            k = 0;
            do @(posedge clk); while (m_valid !== 1'b1 && ++k < 20);
            check(m_data, first + 32'(i));
        end
        m_ready <= 1'b0;
    endtask : drain

    task automatic t_ext_write;
        int k;
        cfg(2'h1, 1'b1, 4'h3, 1'b0);
        s_valid <= 1'b1;
        s_data <= 32'hBEEF0001;
        k = 0;
        do @(posedge clk); while (s_ready !== 1'b1 && ++k < 20);
        s_valid <= 1'b0;
        xfer(0, 32'h0, 4);
        @(posedge clk);
        check(dcap, 32'hBEEF0001);
        check(32'(addr), 32'(BASE) + 32'h1);
        check(32'(busy), 32'h0);
    endtask : t_ext_write

    task automatic t_paced;
        logic [7:0] g;
        g = gcnt;
        cfg(2'h2, 1'b0, 4'h1, 1'b0);
        xfer(1, 32'hC0DE0002, 3);
        check(32'(gcnt - g), 32'h0);
        drain(1, 32'hC0DE0002);
    endtask : t_paced

    task automatic t_idle_gap;
        logic [7:0] d;
        d = dcnt;
        cfg(2'h0, 1'b0, 4'h2, 1'b1);
        xfer(0, 32'hD0000000, 3);
        xfer(0, 32'hD0000001, 3);
        // Second done pulse is counted at this very edge; let it settle
        @(posedge clk);
        check(32'(dcnt - d), 32'h2);
        drain(2, 32'hD0000000);
    endtask : t_idle_gap

    // Reserved mode code must never start an access
    task automatic t_mode_off;
        cfg(2'h3, 1'b0, 4'h0, 1'b0);
        xfer(0, 32'h0, 0);
        check(32'(m_valid), 32'h0);
    endtask : t_mode_off

    // Full FIFO must refuse the ninth request outright
    task automatic t_fill;
        cfg(2'h0, 1'b0, 4'h0, 1'b0);
        xfer(2, 32'hC0DE0001, 4);
        drain(1, 32'hC0DE0001);
        for (int i = 0; i < 9; i++)
            xfer(0, 32'hA0000000 + 32'(i), (i < 8) ? 2 : 0);
        drain(8, 32'hA0000000);
    endtask : t_fill

    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        #(50 * 4000);
        num_errors++;
        close_out();
    end

    initial
    begin
        {rst_n, en, dir, idle, s_valid, m_ready} = 6'h00;
        {mode, waits, s_data} = 38'h0;
        {lowcnt, gcnt, dcnt, dcap} = 56'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check(32'(grant_n), 32'h1);
        check(32'(msel), 32'(SELECT_IDLE));
        t_fill();
        t_ext_write();
        t_paced();
        t_idle_gap();
        t_mode_off();
        close_out();
    end
endmodule : tb
`default_nettype wire
